// ===== verilog/ccdht_pkg.sv
`default_nettype none
package ccdht_pkg;

  // ----------------------------------------
  // grid
  // ----------------------------------------
  localparam int unsigned GRID_STEPS = 48;
  localparam logic [5:0] POS_LAST = 6'h2F;
  localparam logic [5:0] QUAD_SPAN = 6'h0C;
  localparam logic [3:0] QUAD_POS_LAST = 4'hB;

  // ----------------------------------------
  // serial port frame
  // ----------------------------------------
  localparam int unsigned SER_ADDR_BITS = 8;
  localparam int unsigned SER_DATA_BITS = 16;
  localparam logic [4:0] SER_FRAME_BITS = 5'h18;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_CLK_DIVIDE = 8'h30;
  localparam logic [7:0] ADDR_SYNC_MODE = 8'h31;
  localparam logic [7:0] ADDR_LINE_LAST = 8'h32;
  localparam logic [7:0] ADDR_FIELD_LAST = 8'h33;
  localparam logic [7:0] ADDR_GATE_EDGES = 8'h34;
  localparam logic [7:0] ADDR_LAST_EDGES = 8'h35;
  localparam logic [7:0] ADDR_HDRIVE = 8'h36;
  localparam logic [7:0] ADDR_PH1_EDGES = 8'h39;
  localparam logic [7:0] ADDR_PH3_EDGES = 8'h3A;
  localparam logic [7:0] ADDR_SAMPLE_LOC = 8'h3B;
  localparam logic [7:0] ADDR_GATE_DRIVE = 8'h3F;

  // ----------------------------------------
  // field layouts
  // ----------------------------------------
  localparam int unsigned DRV_PH1_LSB = 0;
  localparam int unsigned DRV_PH2_LSB = 3;
  localparam int unsigned DRV_PH3_LSB = 6;
  localparam int unsigned DRV_PH4_LSB = 9;
  localparam int unsigned DRV_LAST_LSB = 12;
  localparam int unsigned SAMP_RST_LSB = 0;
  localparam int unsigned SAMP_DATA_LSB = 6;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [6:0] PIN_IDLE = 7'h08;
  localparam logic RST_CLK_DIVIDE = 1'b0;
  localparam logic RST_MASTER = 1'b1;
  localparam logic [12:0] RST_LINE_LAST = 13'h1FFF;
  localparam logic [11:0] RST_FIELD_LAST = 12'hFFF;
  localparam logic [12:0] RST_EDGES = 13'h0800;
  localparam logic [14:0] RST_HDRIVE = 15'h7FFF;
  localparam logic [2:0] RST_GATE_DRIVE = 3'h7;
  localparam logic [11:0] RST_SAMPLE_LOC = 12'h0800;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic pol;
    logic [5:0] neg;
    logic [5:0] pos;
  } ccdht_edges_t;

  typedef struct packed {
    logic level;
    logic oe;
    logic [2:0] strength;
  } ccdht_pad_t;

  typedef enum logic [2:0] {
    SER_IDLE = 3'b001,
    SER_SHIFT = 3'b010,
    SER_COMMIT = 3'b100
  } ccdht_ser_state_t;

endpackage
`default_nettype wire

// ===== verilog/ccdht_edge.sv
`timescale 1ns/1ps
`default_nettype none
module ccdht_edge (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic step_en,
  input wire logic [5:0] position,
  input wire ccdht_pkg::ccdht_edges_t edges,
  output logic out_reg,
  output logic pos_hit
);

  logic level_reg;
  logic level_next;
  logic neg_hit;

  // code to grid location; low nibble of 12..15 never matches
  function automatic logic code_hit(input logic [5:0] code, input logic [5:0] p);
    logic [5:0] loc;
    loc = 6'(code[5:4] * ccdht_pkg::QUAD_SPAN) + {2'b00, code[3:0]};
    code_hit = (code[3:0] <= ccdht_pkg::QUAD_POS_LAST) && (loc == p);
  endfunction

  assign pos_hit = step_en && code_hit(edges.pos, position);
  assign neg_hit = step_en && code_hit(edges.neg, position);

  // equal codes: negative edge wins, pulse stays inactive
  always_comb
  begin
    level_next = level_reg;
    if (neg_hit)
      level_next = 1'b0;
    else if (pos_hit)
      level_next = 1'b1;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      level_reg <= 1'b0;
    else
      level_reg <= level_next;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      out_reg <= 1'b0;
    else
      out_reg <= level_next ^ edges.pol;
  end

  a_edge_active: assert property (@(posedge core_clk) disable iff (!nrst)
    pos_hit && !neg_hit |=> out_reg == !$past(edges.pol))
    else $error("output not active after positive edge");

  a_edge_inactive: assert property (@(posedge core_clk) disable iff (!nrst)
    neg_hit |=> out_reg == $past(edges.pol))
    else $error("output not inactive after negative edge");

endmodule // ccdht_edge
`default_nettype wire

// ===== verilog/ccdht_core.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - each pixel period is split into 48 edge positions for all edges
// - divide setting halves master clock, letting a double-rate reference serve
// - crystal drive output is always the inverse of master clock input
// - reset gate has programmable rise, fall and whole-pulse polarity
// - last-horizontal, phase one and phase three each have rise, fall, polarity
// - phase two complements phase one, phase four complements phase three
// - edge fields are six bits, 48 valid codes in four quadrants of 12
// - upper two bits quadrant, lower four 0..11; lower 12..15 invalid
// - reset-level and data-level sample strobes at separate six-bit locations
// - three-bit drive on reset gate, last-horizontal and four phases; zero is three-state, steps add strength
// - line counter reaches 8192 pixels, field counter 4096 lines
// - master mode external sync resets counters and realigns sync outputs
// - edge timing identical in master and slave modes
module ccdht_core (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic master_clock_in,
  output logic crystal_drive_out,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_load_n,
  input wire logic ext_sync,
  input wire logic vertical_sync_in,
  output logic vertical_sync_out,
  output logic vertical_sync_oe,
  input wire logic horizontal_sync_in,
  output logic horizontal_sync_out,
  output logic horizontal_sync_oe,
  output ccdht_pkg::ccdht_pad_t reset_gate_clock,
  output ccdht_pkg::ccdht_pad_t horiz_last_clock,
  output ccdht_pkg::ccdht_pad_t horiz_phase_one,
  output ccdht_pkg::ccdht_pad_t horiz_phase_two,
  output ccdht_pkg::ccdht_pad_t horiz_phase_three,
  output ccdht_pkg::ccdht_pad_t horiz_phase_four,
  output logic reset_level_sample,
  output logic data_level_sample
);

  // ----------------------------------------
  // pin input synchronisers
  // ----------------------------------------
  localparam int unsigned NPIN = 7;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_reg;
  logic [NPIN-1:0] s2_reg;
  logic [NPIN-1:0] s3_reg;
  logic [NPIN-1:0] filt_reg;
  logic [NPIN-1:0] filt_prev_reg;
  logic [NPIN-1:0] rise;

  assign pin_raw = {horizontal_sync_in, vertical_sync_in, ext_sync, ser_load_n,
                    ser_data, ser_clk, master_clock_in};

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      // idle pin levels, so no false frame start follows reset
      s1_reg <= ccdht_pkg::PIN_IDLE;
      s2_reg <= ccdht_pkg::PIN_IDLE;
      s3_reg <= ccdht_pkg::PIN_IDLE;
    end
    else
    begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // change accepted only when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_filt
      always_ff @(posedge core_clk or negedge nrst)
      begin
        if (!nrst)
          filt_reg[gi] <= ccdht_pkg::PIN_IDLE[gi];
        else if (s2_reg[gi] == s3_reg[gi])
          filt_reg[gi] <= s3_reg[gi];
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      filt_prev_reg <= ccdht_pkg::PIN_IDLE;
    else
      filt_prev_reg <= filt_reg;
  end

  assign rise = filt_reg & ~filt_prev_reg;

  // ----------------------------------------
  // crystal drive
  // ----------------------------------------
  assign crystal_drive_out = ~master_clock_in;

  // ----------------------------------------
  // serial port
  // ----------------------------------------
  ccdht_pkg::ccdht_ser_state_t ser_state_reg;
  logic [23:0] ser_shift_reg;
  logic [4:0] ser_cnt_reg;
  logic ser_wr;
  logic [7:0] wr_addr;
  logic [15:0] wr_data;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ser_state_reg <= ccdht_pkg::SER_IDLE;
      ser_shift_reg <= 24'h00_0000;
      ser_cnt_reg <= 5'h00;
    end
    else
    begin
      unique case (ser_state_reg)
        ccdht_pkg::SER_IDLE:
          if (!filt_reg[3])
          begin
            ser_cnt_reg <= 5'h00;
            ser_state_reg <= ccdht_pkg::SER_SHIFT;
          end
        ccdht_pkg::SER_SHIFT:
          if (filt_reg[3])
            ser_state_reg <= ccdht_pkg::SER_COMMIT;
          else if (rise[1] && ser_cnt_reg != ccdht_pkg::SER_FRAME_BITS)
          begin
            // address first, then data, each lsb first
            ser_shift_reg <= {filt_reg[2], ser_shift_reg[23:1]};
            ser_cnt_reg <= ser_cnt_reg + 5'h01;
          end
        ccdht_pkg::SER_COMMIT:
          ser_state_reg <= ccdht_pkg::SER_IDLE;
      endcase
    end
  end

  // short frames are dropped
  assign ser_wr = (ser_state_reg == ccdht_pkg::SER_COMMIT) &&
                  (ser_cnt_reg == ccdht_pkg::SER_FRAME_BITS);
  assign wr_addr = ser_shift_reg[7:0];
  assign wr_data = ser_shift_reg[23:8];

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic master_clock_divide_reg;
  logic master_mode_reg;
  logic [12:0] line_last_reg;
  logic [11:0] field_last_reg;
  ccdht_pkg::ccdht_edges_t gate_edges_reg;
  ccdht_pkg::ccdht_edges_t last_edges_reg;
  ccdht_pkg::ccdht_edges_t ph1_edges_reg;
  ccdht_pkg::ccdht_edges_t ph3_edges_reg;
  logic [11:0] sample_loc_reg;
  logic [14:0] horizontal_drive_strength_reg;
  logic [2:0] gate_drive_strength_reg;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      master_clock_divide_reg <= ccdht_pkg::RST_CLK_DIVIDE;
      master_mode_reg <= ccdht_pkg::RST_MASTER;
      line_last_reg <= ccdht_pkg::RST_LINE_LAST;
      field_last_reg <= ccdht_pkg::RST_FIELD_LAST;
      gate_edges_reg <= ccdht_pkg::RST_EDGES;
      last_edges_reg <= ccdht_pkg::RST_EDGES;
      ph1_edges_reg <= ccdht_pkg::RST_EDGES;
      ph3_edges_reg <= ccdht_pkg::RST_EDGES;
      sample_loc_reg <= ccdht_pkg::RST_SAMPLE_LOC;
      horizontal_drive_strength_reg <= ccdht_pkg::RST_HDRIVE;
      gate_drive_strength_reg <= ccdht_pkg::RST_GATE_DRIVE;
    end
    else if (ser_wr)
    begin
      unique case (wr_addr)
        ccdht_pkg::ADDR_CLK_DIVIDE: master_clock_divide_reg <= wr_data[0];
        ccdht_pkg::ADDR_SYNC_MODE: master_mode_reg <= wr_data[0];
        ccdht_pkg::ADDR_LINE_LAST: line_last_reg <= wr_data[12:0];
        ccdht_pkg::ADDR_FIELD_LAST: field_last_reg <= wr_data[11:0];
        ccdht_pkg::ADDR_GATE_EDGES: gate_edges_reg <= wr_data[12:0];
        ccdht_pkg::ADDR_LAST_EDGES: last_edges_reg <= wr_data[12:0];
        ccdht_pkg::ADDR_PH1_EDGES: ph1_edges_reg <= wr_data[12:0];
        ccdht_pkg::ADDR_PH3_EDGES: ph3_edges_reg <= wr_data[12:0];
        ccdht_pkg::ADDR_SAMPLE_LOC: sample_loc_reg <= wr_data[11:0];
        ccdht_pkg::ADDR_HDRIVE: horizontal_drive_strength_reg <= wr_data[14:0];
        ccdht_pkg::ADDR_GATE_DRIVE: gate_drive_strength_reg <= wr_data[2:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // pixel period and edge grid
  // ----------------------------------------
  logic half_reg;
  logic pix_start;
  logic step_en;
  logic [5:0] position_reg;

  // divide mode: every other master clock rise opens a pixel
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      half_reg <= 1'b0;
    else if (rise[0])
      half_reg <= master_clock_divide_reg ? ~half_reg : 1'b0;
  end

  assign pix_start = rise[0] && (!master_clock_divide_reg || half_reg);

  // each step, the last one too, is matched once; the park is not a step
  logic run_reg;
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      run_reg <= 1'b0;
    else if (pix_start)
      run_reg <= 1'b1;
    else if (position_reg == ccdht_pkg::POS_LAST)
      run_reg <= 1'b0;
  end

  assign step_en = run_reg;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      position_reg <= ccdht_pkg::POS_LAST;
    else if (pix_start)
      position_reg <= 6'h00;
    else if (step_en && position_reg != ccdht_pkg::POS_LAST)
      position_reg <= position_reg + 6'h01;
  end

  // ----------------------------------------
  // edge channels, same in both sync modes
  // ----------------------------------------
  logic gate_lvl;
  logic last_lvl;
  logic ph1_lvl;
  logic ph3_lvl;
  logic rsmp_hit;
  logic dsmp_hit;
  ccdht_pkg::ccdht_edges_t rsmp_edges;
  ccdht_pkg::ccdht_edges_t dsmp_edges;

  assign rsmp_edges = {1'b0, 6'h0C, sample_loc_reg[ccdht_pkg::SAMP_RST_LSB +: 6]};
  assign dsmp_edges = {1'b0, 6'h0C, sample_loc_reg[ccdht_pkg::SAMP_DATA_LSB +: 6]};

  ccdht_edge u_gate (.core_clk(core_clk), .nrst(nrst), .step_en(step_en),
    .position(position_reg), .edges(gate_edges_reg), .out_reg(gate_lvl), .pos_hit());
  ccdht_edge u_last (.core_clk(core_clk), .nrst(nrst), .step_en(step_en),
    .position(position_reg), .edges(last_edges_reg), .out_reg(last_lvl), .pos_hit());
  ccdht_edge u_ph1 (.core_clk(core_clk), .nrst(nrst), .step_en(step_en),
    .position(position_reg), .edges(ph1_edges_reg), .out_reg(ph1_lvl), .pos_hit());
  ccdht_edge u_ph3 (.core_clk(core_clk), .nrst(nrst), .step_en(step_en),
    .position(position_reg), .edges(ph3_edges_reg), .out_reg(ph3_lvl), .pos_hit());
  ccdht_edge u_rsmp (.core_clk(core_clk), .nrst(nrst), .step_en(step_en),
    .position(position_reg), .edges(rsmp_edges), .out_reg(), .pos_hit(rsmp_hit));
  ccdht_edge u_dsmp (.core_clk(core_clk), .nrst(nrst), .step_en(step_en),
    .position(position_reg), .edges(dsmp_edges), .out_reg(), .pos_hit(dsmp_hit));

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reset_level_sample <= 1'b0;
      data_level_sample <= 1'b0;
    end
    else
    begin
      reset_level_sample <= rsmp_hit;
      data_level_sample <= dsmp_hit;
    end
  end

  // ----------------------------------------
  // pads: level, enable, drive code
  // ----------------------------------------
  function automatic ccdht_pkg::ccdht_pad_t pad(input logic lvl, input logic [2:0] drv);
    pad = '{level: lvl, oe: (drv != 3'h0), strength: drv};
  endfunction

  logic [14:0] hdrv;
  assign hdrv = horizontal_drive_strength_reg;
  assign reset_gate_clock = pad(gate_lvl, gate_drive_strength_reg);
  assign horiz_last_clock = pad(last_lvl, hdrv[ccdht_pkg::DRV_LAST_LSB +: 3]);
  assign horiz_phase_one = pad(ph1_lvl, hdrv[ccdht_pkg::DRV_PH1_LSB +: 3]);
  assign horiz_phase_two = pad(~ph1_lvl, hdrv[ccdht_pkg::DRV_PH2_LSB +: 3]);
  assign horiz_phase_three = pad(ph3_lvl, hdrv[ccdht_pkg::DRV_PH3_LSB +: 3]);
  assign horiz_phase_four = pad(~ph3_lvl, hdrv[ccdht_pkg::DRV_PH4_LSB +: 3]);

  // ----------------------------------------
  // line and field counters
  // ----------------------------------------
  logic [12:0] hcount_reg;
  logic [11:0] vcount_reg;
  logic line_end;

  assign line_end = (hcount_reg == line_last_reg);

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hcount_reg <= 13'h0000;
      vcount_reg <= 12'h000;
    end
    else if (master_mode_reg)
    begin
      if (rise[4])
      begin
        hcount_reg <= 13'h0000;
        vcount_reg <= 12'h000;
      end
      else if (pix_start)
      begin
        hcount_reg <= line_end ? 13'h0000 : hcount_reg + 13'h0001;
        if (line_end)
          vcount_reg <= (vcount_reg == field_last_reg) ? 12'h000 : vcount_reg + 12'h001;
      end
    end
    else
    begin
      if (rise[6])
        hcount_reg <= 13'h0000;
      else if (pix_start)
        hcount_reg <= hcount_reg + 13'h0001;
      if (rise[5])
        vcount_reg <= 12'h000;
      else if (rise[6])
        vcount_reg <= vcount_reg + 12'h001;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      horizontal_sync_out <= 1'b0;
      vertical_sync_out <= 1'b0;
    end
    else
    begin
      horizontal_sync_out <= master_mode_reg && (hcount_reg == 13'h0000);
      vertical_sync_out <= master_mode_reg && (vcount_reg == 12'h000);
    end
  end

  assign horizontal_sync_oe = master_mode_reg;
  assign vertical_sync_oe = master_mode_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [1:0] rises_reg;
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      rises_reg <= 2'h0;
    else if (pix_start)
      rises_reg <= 2'h0;
    else if (rise[0] && rises_reg != 2'h3)
      rises_reg <= rises_reg + 2'h1;
  end

  sequence s_ext_sync;
    master_mode_reg && rise[4];
  endsequence

  sequence s_counters_cleared;
    hcount_reg == 13'h0000 && vcount_reg == 12'h000 ##1 horizontal_sync_out;
  endsequence

  a_xtal_inverse: assert property (@(posedge core_clk) disable iff (!nrst)
    crystal_drive_out != master_clock_in)
    else $error("crystal drive not inverse of master clock");

  a_phase_two_compl: assert property (@(posedge core_clk) disable iff (!nrst)
    horiz_phase_two.level == !horiz_phase_one.level)
    else $error("phase two not complement of phase one");

  a_phase_four_compl: assert property (@(posedge core_clk) disable iff (!nrst)
    horiz_phase_four.level == !horiz_phase_three.level)
    else $error("phase four not complement of phase three");

  a_grid_walk: assert property (@(posedge core_clk) disable iff (!nrst)
    pix_start ##1 !pix_start [*8] |-> position_reg == 6'h07)
    else $error("edge grid not stepping from zero");

  a_divide_skip: assert property (@(posedge core_clk) disable iff (!nrst)
    pix_start && master_clock_divide_reg && $stable(master_clock_divide_reg)
      |-> rises_reg != 2'h0)
    else $error("divide mode started pixel on consecutive rises");

  a_drive_off: assert property (@(posedge core_clk) disable iff (!nrst)
    (gate_drive_strength_reg == 3'h0) |-> !reset_gate_clock.oe)
    else $error("reset gate driven with zero drive code");

  a_ext_sync_reset: assert property (@(posedge core_clk) disable iff (!nrst)
    s_ext_sync |=> s_counters_cleared)
    else $error("external sync did not realign counters");

  a_slave_align: assert property (@(posedge core_clk) disable iff (!nrst)
    !master_mode_reg && rise[6] |=> hcount_reg == 13'h0000 && !horizontal_sync_oe)
    else $error("slave line sync not aligned");

  a_sample_pulse: assert property (@(posedge core_clk) disable iff (!nrst)
    data_level_sample |=> !data_level_sample)
    else $error("data sample strobe longer than one cycle");

endmodule // ccdht_core
`default_nettype wire

// ===== bench/ccdht_ccd_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// sensor horizontal register
// ----------------------------------------
module ccdht_ccd_model (
  input wire logic core_clk,
  input wire ccdht_pkg::ccdht_pad_t phase_a,
  input wire ccdht_pkg::ccdht_pad_t phase_b,
  output var int xfer_count
);
  int cnt = 0;
  logic last_level = 1'b0;
  assign xfer_count = cnt;
  // charge only moves when both phases are driven; a floating phase shifts nothing
  always @(negedge core_clk)
  begin
    if (phase_a.level === 1'b1 && last_level === 1'b0 && phase_a.oe && phase_b.oe)
      cnt <= cnt + 1;
    last_level <= phase_a.level;
  end
endmodule // ccdht_ccd_model
`default_nettype wire

// ===== bench/ccdht_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ccdht_core_tb_top;
  logic core_clk, nrst, master_clock_in, ser_clk, ser_data, ser_load_n, pol;
  logic ext_sync, hs_in, vs_in;
  wire logic crystal_drive_out, vs_out, vs_oe, hs_out, hs_oe, rls, dls;
  ccdht_pkg::ccdht_pad_t gate_p, last_p, ph1, ph2, ph3, ph4;
  wire logic [3:0] lvls;
  wire logic [1:0] smp;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  int xfers, a, b, w, g, c0, nh, nv;
  logic [15:0] rnd = 16'h441A;
  logic [14:0] drv;
  logic [4:0] oe_e;
  logic [7:0] edge_addr [4] = '{ccdht_pkg::ADDR_GATE_EDGES, ccdht_pkg::ADDR_LAST_EDGES,
    ccdht_pkg::ADDR_PH1_EDGES, ccdht_pkg::ADDR_PH3_EDGES};
  assign lvls = {ph3.level, ph1.level, last_p.level, gate_p.level};
  assign smp = {dls, rls};

  ccdht_core ccdht_core_i (.core_clk(core_clk), .nrst(nrst), .master_clock_in(master_clock_in),
    .crystal_drive_out(crystal_drive_out), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_load_n(ser_load_n), .ext_sync(ext_sync), .vertical_sync_in(vs_in),
    .vertical_sync_out(vs_out), .vertical_sync_oe(vs_oe), .horizontal_sync_in(hs_in),
    .horizontal_sync_out(hs_out), .horizontal_sync_oe(hs_oe), .reset_gate_clock(gate_p),
    .horiz_last_clock(last_p), .horiz_phase_one(ph1), .horiz_phase_two(ph2),
    .horiz_phase_three(ph3), .horiz_phase_four(ph4), .reset_level_sample(rls),
    .data_level_sample(dls));
  ccdht_ccd_model ccdht_ccd_model_i (.core_clk(core_clk), .phase_a(ph1), .phase_b(ph2),
    .xfer_count(xfers));

  // ----------------------------------------
  // clocks and helpers
  // ----------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // pixel-rate master clock, 60 core clocks so the whole grid fits
  initial
  begin
    master_clock_in = 1'b0;
    forever
    begin
      repeat (30) @(negedge core_clk);
      master_clock_in = ~master_clock_in;
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [5:0] code_of(input int l);
    return 6'((l / 12) * 16 + l % 12);
  endfunction
  task automatic chk_int(input int got, input int exp);
    compares++;
    if (got != exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_vec(input logic [14:0] got, input logic [14:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic ser_write(input logic [7:0] adr, input logic [15:0] dat);
    logic [23:0] frame;
    frame = {dat, adr};
    ser_load_n = 1'b0;
    for (int i = 0; i < 24; i++)
    begin
      ser_data = frame[i];
      repeat (4) @(negedge core_clk);
      ser_clk = 1'b1;
      repeat (4) @(negedge core_clk);
      ser_clk = 1'b0;
    end
    repeat (4) @(negedge core_clk);
    ser_load_n = 1'b1;
    repeat (8) @(negedge core_clk);
  endtask
  // active width of one edge output; -1 when it never turns active
  task automatic width(input int sel, input logic act, output int wd);
    logic p;
    int n;
    repeat (120) @(negedge core_clk);
    p = lvls[sel];
    for (n = 0; n < 200; n++)
    begin
      @(negedge core_clk);
      if (p !== act && lvls[sel] === act)
        break;
      p = lvls[sel];
    end
    wd = -1;
    if (n < 200)
    begin
      wd = 0;
      while (lvls[sel] === act && wd < 100)
      begin
        @(negedge core_clk);
        wd++;
      end
    end
  endtask
  task automatic gap(input int sa, input int sb, output int gd);
    int n;
    repeat (120) @(negedge core_clk);
    for (n = 0; n < 300 && smp[sa] !== 1'b1; n++)
      @(negedge core_clk);
    gd = 0;
    do
    begin
      @(negedge core_clk);
      gd++;
    end while (smp[sb] !== 1'b1 && gd < 300);
  endtask

  always @(posedge core_clk)
  begin
    if (nrst === 1'b1)
      chk_vec({14'h0, crystal_drive_out}, {14'h0, ~master_clock_in});
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      end_of_test();
    end
  end
  always @(negedge core_clk)
    if (nrst === 1'b1)
      chk_vec({13'h0, ph2.level, ph4.level}, {13'h0, ~ph1.level, ~ph3.level});

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    nrst = 1'b0;
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_load_n = 1'b1;
    ext_sync = 1'b0;
    hs_in = 1'b0;
    vs_in = 1'b0;
    repeat (4) @(negedge core_clk);
    nrst = 1'b1;
    repeat (8) @(negedge core_clk);
    chk_vec({last_p.strength, ph4.strength, ph3.strength, ph2.strength, ph1.strength},
      15'h7FFF);
    chk_vec({13'h0, vs_oe, hs_oe}, 15'h0003);
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      a = (i == 0) ? 0 : rnd[5:0] % 47;
      b = (i == 0) ? 47 : a + 1 + rnd[12:7] % (47 - a);
      pol = rnd[15];
      ser_write(edge_addr[i % 4], {3'h0, pol, code_of(b), code_of(a)});
      width(i % 4, ~pol, w);
      chk_int(w, b - a);
    end
    ser_write(ccdht_pkg::ADDR_PH1_EDGES, {4'h0, 6'h20, 6'h0C});
    width(2, 1'b1, w);
    chk_int(w, -1);
    ser_write(ccdht_pkg::ADDR_PH1_EDGES, {4'h0, code_of(30), code_of(5)});
    ser_write(ccdht_pkg::ADDR_PH3_EDGES, {4'h0, code_of(30), code_of(5)});
    width(2, 1'b1, w);
    chk_int(w, 25);
    for (int i = 0; i < 60; i++)
    begin
      @(negedge core_clk);
      chk_vec({14'h0, ph3.level}, {14'h0, ph1.level});
    end
    c0 = xfers;
    repeat (600) @(negedge core_clk);
    chk_int(xfers - c0, 10);
    gap(0, 0, g);
    chk_int(g, 60);
    rnd = lfsr(rnd);
    a = rnd[5:0] % 47;
    b = a + 1 + rnd[12:7] % (47 - a);
    ser_write(ccdht_pkg::ADDR_SAMPLE_LOC, {4'h0, code_of(b), code_of(a)});
    gap(0, 1, g);
    chk_int(g, b - a);
    // four pixels a line, two lines a field
    ser_write(ccdht_pkg::ADDR_LINE_LAST, 16'h0003);
    ser_write(ccdht_pkg::ADDR_FIELD_LAST, 16'h0001);
    // sync lands with a master clock rise, so the pixel it opens is pixel zero
    @(posedge master_clock_in);
    ext_sync = 1'b1;
    repeat (8) @(negedge core_clk);
    ext_sync = 1'b0;
    chk_vec({13'h0, vs_out, hs_out}, 15'h0003);
    nh = 0;
    nv = 0;
    repeat (480)
    begin
      @(negedge core_clk);
      nh += hs_out;
      nv += vs_out;
    end
    chk_int(nh, 120);
    chk_int(nv, 240);
    ser_write(ccdht_pkg::ADDR_SYNC_MODE, 16'h0000);
    chk_vec({13'h0, vs_oe, hs_oe}, 15'h0000);
    hs_in = 1'b1;
    vs_in = 1'b1;
    repeat (8) @(negedge core_clk);
    hs_in = 1'b0;
    vs_in = 1'b0;
    repeat (4) @(negedge core_clk);
    chk_vec({13'h0, vs_out, hs_out}, 15'h0000);
    width(2, 1'b1, w);
    chk_int(w, 25);
    rnd = lfsr(rnd);
    drv = {rnd[14:3], 3'h0};
    for (int j = 0; j < 5; j++)
      oe_e[j] = (drv[3 * j +: 3] != 3'h0);
    ser_write(ccdht_pkg::ADDR_HDRIVE, {1'b0, drv});
    ser_write(ccdht_pkg::ADDR_GATE_DRIVE, {13'h0, rnd[2:0]});
    ser_write(8'h37, 16'h0000);
    repeat (70) @(negedge core_clk);
    chk_vec({last_p.strength, ph4.strength, ph3.strength, ph2.strength, ph1.strength},
      drv);
    chk_vec({10'h0, last_p.oe, ph4.oe, ph3.oe, ph2.oe, ph1.oe}, {10'h0, oe_e});
    chk_vec({11'h0, gate_p.oe, gate_p.strength}, {11'h0, rnd[2:0] != 3'h0, rnd[2:0]});
    ser_write(ccdht_pkg::ADDR_CLK_DIVIDE, 16'h0001);
    gap(0, 0, g);
    gap(0, 0, g);
    chk_int(g, 120);
    end_of_test();
  end
endmodule // ccdht_core_tb_top
`default_nettype wire
